//--- rtl/ackr_defs.vh
`ifndef ACKR_DEFS_VH
`define ACKR_DEFS_VH
// register byte offsets
`define ACKR_OFS_CLOCK_CONFIG_ONE      8'h00
`define ACKR_OFS_CLOCK_CONFIG_TWO      8'h04
`define ACKR_OFS_ASYS      8'h08
`define ACKR_OFS_STAT1     8'h0c
`define ACKR_OFS_STATP     8'h10
`define ACKR_OFS_STATN     8'h14
// clock_config_one fields
`define ACKR_SRC_BIT       7
`define ACKR_CDIV_LSB      1
// clock_config_two fields
`define ACKR_MDIV_LSB      5
`define ACKR_OSR_LSB       0
// analog_system_config fields
`define ACKR_LVL_BIT       4
`define ACKR_IREF_BIT      3
`define ACKR_TH_LSB        0
// status one field
`define ACKR_OOR_BIT       0
// reset values
`define ACKR_RST_CLOCK_CONFIG_ONE      8'h08
`define ACKR_RST_CLOCK_CONFIG_TWO      8'h86
`define ACKR_RST_ASYS      8'h00
// htrans nonseq / seq bit
`define ACKR_HTRANS_ACT    1
`endif

//--- rtl/ackr_top.v
// What this block does
// - system clock divides master clock input
// - serial clock may be system clock
// - master mode drives system clock out
// - source bit picks divided or serial
// - modulator clock divides system clock
// - data rate is modulator over ratio
// - per channel high and low comparators
// - any pin over threshold sets flag
// - per pin status tells which pin
// - reference source resets external, 1 internal
// - level bit default selects lower level
// - level bit ignored with external reference
// - all modulators sample together
// - ratio applies to every channel
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "ackr_defs.vh"
module ackr_top #(
  parameter NCH = 4
) (
  input  wire            sys_clk,      // system clock
  input  wire            rst_n,        // sync reset, low
  input  wire            haddr_sel,    // hsel
  input  wire [31:0]     haddr,        // address
  input  wire [1:0]      htrans,       // transfer type
  input  wire            hwrite,       // write
  input  wire [2:0]      hsize,        // size
  input  wire [31:0]     hwdata,       // write data
  input  wire            hready,       // bus ready
  output wire [31:0]     hrdata,       // read data
  output wire            hreadyout,    // slave ready
  output wire            hresp,        // always okay
  input  wire            masterClockTick,  // master clock edge
  input  wire            serialClockTick,  // serial clock edge
  input  wire            syncMasterMode,   // synchronous master
  input  wire            syncSlaveMode,    // synchronous slave
  input  wire [NCH-1:0]  posOverTh,    // p pin beyond limit
  input  wire [NCH-1:0]  negOverTh,    // n pin beyond limit
  output reg             sysClkTick,   // system clock pulse
  output reg             serialClkOut, // serial clock out
  output reg             modClkTick,   // modulator clock pulse
  output reg             dataReady,    // result pulse
  output reg  [2:0]      thresholdCode,// threshold dac code
  output reg             useInternalRef, // internal reference
  output reg             refHighLevel  // higher level chosen
);
  // configuration registers
  reg  [7:0] clkOne_reg, clkTwo_reg, aSys_reg;

  // sticky status
  reg        oorFlag_reg;
  wire [NCH-1:0] statP_reg, statN_reg;

  // bus data phase state
  reg        dpWr_reg, dpRd_reg;
  reg  [7:0] dpAddr_reg;

  // divider and rate counters
  reg  [2:0] sysCnt_reg, modCnt_reg;
  reg  [11:0] osrCnt_reg;
  reg  [11:0] osrLen;

  // read mux output
  reg  [31:0] rdData;
  wire       addrAct;
  wire       srcSerial;
  wire [2:0] clkDiv;
  wire [2:0] modDiv;
  wire [3:0] osrSel;
  wire       srcTick;
  wire       rdP, rdN, rdS;
  wire [NCH-1:0] posHit, negHit;
  // divider wrap strobes and combined hit
  wire       sysWrap, modWrap, osrWrap;
  wire       anyHit;
  // per register write strobes
  wire       wrClkOne, wrClkTwo, wrASys;

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // a transfer starts on a selected active slot
  assign addrAct = haddr_sel & hready & htrans[`ACKR_HTRANS_ACT];

  // decoded configuration fields
  assign srcSerial = clkOne_reg[`ACKR_SRC_BIT];
  assign clkDiv = clkOne_reg[`ACKR_CDIV_LSB+:3];
  assign modDiv = clkTwo_reg[`ACKR_MDIV_LSB+:3];
  assign osrSel = clkTwo_reg[`ACKR_OSR_LSB+:4];
  assign posHit = posOverTh;
  assign negHit = negOverTh;
  assign anyHit = (|posHit) | (|negHit);

  // bus address phase capture
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dpWr_reg   <= 1'b0;
      dpRd_reg   <= 1'b0;
      dpAddr_reg <= 8'h00;
    end else begin
      dpWr_reg   <= addrAct & hwrite;
      dpRd_reg   <= addrAct & ~hwrite;
      if (addrAct)
        dpAddr_reg <= haddr[7:0];
    end
  end

  // write strobes in the data phase, unmapped writes dropped
  assign wrClkOne = dpWr_reg & (dpAddr_reg == `ACKR_OFS_CLOCK_CONFIG_ONE);
  assign wrClkTwo = dpWr_reg & (dpAddr_reg == `ACKR_OFS_CLOCK_CONFIG_TWO);
  assign wrASys   = dpWr_reg & (dpAddr_reg == `ACKR_OFS_ASYS);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      clkOne_reg <= `ACKR_RST_CLOCK_CONFIG_ONE;
    end else if (wrClkOne) begin
      clkOne_reg <= hwdata[7:0];
    end
  end

  // modulator divider and ratio field
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      clkTwo_reg <= `ACKR_RST_CLOCK_CONFIG_TWO;
    end else if (wrClkTwo) begin
      clkTwo_reg <= hwdata[7:0];
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      aSys_reg <= `ACKR_RST_ASYS;
    end else if (wrASys) begin
      aSys_reg <= hwdata[7:0];
    end
  end

  assign rdS = dpRd_reg & (dpAddr_reg == `ACKR_OFS_STAT1);
  assign rdP = dpRd_reg & (dpAddr_reg == `ACKR_OFS_STATP);
  assign rdN = dpRd_reg & (dpAddr_reg == `ACKR_OFS_STATN);

  // read mux, unmapped reads zero
  always @* begin
    rdData = 32'h0000_0000;
    case (dpAddr_reg)
      `ACKR_OFS_CLOCK_CONFIG_ONE:  rdData[7:0] = clkOne_reg;
      `ACKR_OFS_CLOCK_CONFIG_TWO:  rdData[7:0] = clkTwo_reg;
      `ACKR_OFS_ASYS:  rdData[7:0] = aSys_reg;
      `ACKR_OFS_STAT1: rdData[`ACKR_OOR_BIT] = oorFlag_reg;
      `ACKR_OFS_STATP: rdData[NCH-1:0] = statP_reg;
      `ACKR_OFS_STATN: rdData[NCH-1:0] = statN_reg;
      default:         rdData = 32'h0000_0000;
    endcase
  end
  assign hrdata = dpRd_reg ? rdData : 32'h0000_0000;

  // any pin sets flag, set wins over read clear
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      oorFlag_reg <= 1'b0;
    end else begin
      oorFlag_reg <= anyHit | (oorFlag_reg & ~rdS);
    end
  end

  // status pair, one copy per channel
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_pin
      reg pBit_reg;
      reg nBit_reg;
      // per pin status, set wins over clear
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          pBit_reg <= 1'b0;
          nBit_reg <= 1'b0;
        end else begin
          pBit_reg <= posHit[ch] | (pBit_reg & ~rdP);
          nBit_reg <= negHit[ch] | (nBit_reg & ~rdN);
        end
      end
      // status bits seen by the read mux
      assign statP_reg[ch] = pBit_reg;
      assign statN_reg[ch] = nBit_reg;
    end
  endgenerate

  assign srcTick = srcSerial ? (serialClockTick & syncSlaveMode)
                             : masterClockTick;

  // oversampling ratio lookup
  always @* begin
    case (osrSel)
      4'h0: osrLen = 12'd4095;
      4'h1: osrLen = 12'd2047;
      4'h2: osrLen = 12'd1023;
      4'h3: osrLen = 12'd799;
      4'h4: osrLen = 12'd767;
      4'h5: osrLen = 12'd511;
      4'h6: osrLen = 12'd399;
      4'h7: osrLen = 12'd383;
      4'h8: osrLen = 12'd255;
      4'h9: osrLen = 12'd199;
      4'ha: osrLen = 12'd191;
      4'hb: osrLen = 12'd127;
      4'hc: osrLen = 12'd95;
      4'hd: osrLen = 12'd63;
      4'he: osrLen = 12'd47;
      default: osrLen = 12'd31;
    endcase
  end

  // system divider wraps on its last source tick
  assign sysWrap = srcTick & (srcSerial | (sysCnt_reg >= clkDiv));
  // modulator divider wraps on its last system tick
  assign modWrap = sysClkTick & (modCnt_reg >= modDiv);
  // rate counter wraps after a full ratio of modulator ticks
  assign osrWrap = modClkTick & (osrCnt_reg >= osrLen);

  // divide master clock by field plus one
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sysCnt_reg <= 3'h0;
    end else if (sysWrap) begin
      sysCnt_reg <= 3'h0;
    end else if (srcTick) begin
      sysCnt_reg <= sysCnt_reg + 3'h1;
    end
  end

  // serial source gives a tick per edge in slave mode
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sysClkTick <= 1'b0;
    end else begin
      sysClkTick <= sysWrap;
    end
  end

  // drive serial clock out, low outside master mode
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      serialClkOut <= 1'b0;
    end else if (!syncMasterMode) begin
      serialClkOut <= 1'b0;
    end else if (sysWrap) begin
      serialClkOut <= ~serialClkOut;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      modCnt_reg <= 3'h0;
    end else if (modWrap) begin
      modCnt_reg <= 3'h0;
    end else if (sysClkTick) begin
      modCnt_reg <= modCnt_reg + 3'h1;
    end
  end

  // one shared modulator tick for all channels
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      modClkTick <= 1'b0;
    end else begin
      modClkTick <= modWrap;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      osrCnt_reg <= 12'h000;
    end else if (osrWrap) begin
      osrCnt_reg <= 12'h000;
    end else if (modClkTick) begin
      osrCnt_reg <= osrCnt_reg + 12'h001;
    end
  end

  // one global data ready for all channels
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dataReady <= 1'b0;
    end else begin
      dataReady <= osrWrap;
    end
  end

  // threshold dac code follows its field
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      thresholdCode <= 3'h0;
    end else begin
      thresholdCode <= aSys_reg[`ACKR_TH_LSB+:3];
    end
  end

  // reference source follows its select bit
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      useInternalRef <= 1'b0;
    end else begin
      useInternalRef <= aSys_reg[`ACKR_IREF_BIT];
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      refHighLevel <= 1'b0;
    end else begin
      refHighLevel <= aSys_reg[`ACKR_IREF_BIT] &
                      aSys_reg[`ACKR_LVL_BIT];
    end
  end
endmodule

//--- tb/ackr_far_model.sv
`timescale 1ns/10ps
module ackr_far_model #(
  parameter int STARTUP = 20, // short crystal start up
  parameter int PERIOD  = 3   // cycles per clock edge
) (
  input  logic       sys_clk,                // clock
  input  logic       masterEn,               // run master clock
  input  logic       serialEn,               // run serial clock
  input  logic [3:0] hitP,                   // p pin event
  input  logic [3:0] hitN,                   // n pin event
  output logic       masterClockTick = '0,   // master edge
  output logic       serialClockTick = '0,   // serial edge
  output logic [3:0] posOverTh       = '0,   // p comparators
  output logic [3:0] negOverTh       = '0    // n comparators
);
  int cnt = 0;
  int up  = 0;
  // crystal start up
  // master edges only once the oscillator has started
  always @(posedge sys_clk) begin
    up <= (up < STARTUP) ? up + 1 : up;
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    masterClockTick <= masterEn && up == STARTUP && cnt == 0;
    serialClockTick <= serialEn && cnt == 0;
    posOverTh <= hitP;
    negOverTh <= hitN;
  end
endmodule

//--- tb/ackr_monitor.sv
`timescale 1ns/10ps
module ackr_monitor (
  input logic sys_clk,         // clock
  input logic rst_n,           // reset
  input logic hreadyout,       // ready
  input logic hresp,           // response
  input logic masterClockTick, // master edge
  input logic serialClockTick, // serial edge
  input logic syncMasterMode,  // master mode
  input logic syncSlaveMode,   // slave mode
  input logic sysClkTick,      // system tick
  input logic serialClkOut,    // serial out
  input logic modClkTick,      // mod tick
  input logic dataReady,       // result
  input logic useInternalRef,  // internal ref
  input logic refHighLevel     // high level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // bus answer
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready okay");
  a_ref_reset: assert property ($rose(rst_n) |-> !useInternalRef)
    else $error("ref not external");
  a_level_gated: assert property (!useInternalRef |-> !refHighLevel)
    else $error("level without ref");
  a_sys_cause: assert property (sysClkTick |->
    $past(masterClockTick) || $past(serialClockTick))
    else $error("sys tick no source");
  a_serial_src: assert property (
    sysClkTick && !$past(masterClockTick) |-> $past(syncSlaveMode))
    else $error("serial source outside slave");
  a_mod_cause: assert property (modClkTick |-> $past(sysClkTick))
    else $error("mod tick no sys tick");
  a_mod_single: assert property (modClkTick |=> !modClkTick)
    else $error("mod tick too long");
  a_rate_cause: assert property (dataReady |-> $past(modClkTick))
    else $error("result no mod tick");
  a_sclk_idle: assert property (!syncMasterMode |=> !serialClkOut)
    else $error("serial out driven");
  // serial out toggles per system tick in master mode
  a_sclk_toggle: assert property (
    sysClkTick && $past(syncMasterMode) |->
    serialClkOut != $past(serialClkOut))
    else $error("serial out not toggling");
  c_ready: cover property (dataReady);
  c_slave: cover property (sysClkTick && syncSlaveMode);
  c_high: cover property (refHighLevel);
endmodule
bind ackr_top ackr_monitor u_mon (.sys_clk, .rst_n, .hreadyout, .hresp,
  .masterClockTick, .serialClockTick, .syncMasterMode, .syncSlaveMode,
  .sysClkTick, .serialClkOut, .modClkTick, .dataReady, .useInternalRef,
  .refHighLevel);

//--- tb/ackr_tb_top.sv
`timescale 1ns/10ps
module ackr_tb_top;
  logic sys_clk = '0, rst_n = '0, hwrite = '0, rdPhase = '0;
  logic haddr_sel = 1'h1, syncMasterMode = '0, syncSlaveMode = '0;
  logic mEn = '0, sEn = '0, hreadyout, hresp, masterClockTick;
  logic serialClockTick, sysClkTick, serialClkOut, modClkTick;
  logic dataReady, useInternalRef, refHighLevel;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, expQ[$];
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2, thresholdCode, th;
  logic [3:0] posOverTh, negOverTh, hitP = '0, hitN = '0;
  wire hready = hreadyout;
  int mismatches = 0, checksDone = 0, seed, pin, d;
  int src[3] = '{0, 0, 1}, mdv[3] = '{0, 1, 0};
  int osc[3] = '{15, 14, 15}, osv[3] = '{32, 48, 32};
  always #5 sys_clk = ~sys_clk;
  ackr_top u_dut (.sys_clk, .rst_n, .haddr_sel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .masterClockTick,
    .serialClockTick, .syncMasterMode, .syncSlaveMode, .posOverTh,
    .negOverTh, .sysClkTick, .serialClkOut, .modClkTick, .dataReady,
    .thresholdCode, .useInternalRef, .refHighLevel);
  ackr_far_model u_far (.sys_clk, .masterEn(mEn), .serialEn(sEn), .hitP,
    .hitN, .masterClockTick, .serialClockTick, .posOverTh, .negOverTh);
  task chk(input logic [31:0] got, exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task bus(input logic w, input logic [31:0] a, v);
    @(posedge sys_clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= v;
    rdPhase <= !w;
    do @(posedge sys_clk); while (hready !== 1'h1);
    rdPhase <= 1'h0;
  endtask
  task rd(input logic [31:0] a, e);
    expQ.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask
  task rate(input int e);
    time t0;
    repeat (2) @(posedge dataReady);
    t0 = $time;
    @(posedge dataReady);
    chk(32'(($time - t0) / 10), e);
  endtask
  // read data phase against oldest note
  always @(posedge sys_clk)
    if (rdPhase) chk(hrdata, expQ.pop_front());
  // hang guard
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
  initial begin
    seed = $urandom(32'h1bc9);
    th = $urandom;
    pin = $urandom % 4;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(32'h0, 32'h08);
    rd(32'h4, 32'h86);
    rd(32'h8, 32'h0);
    rd(32'h20, 32'h0);
    bus(1'h1, 32'h8, 32'h10 | th);
    repeat (2) @(posedge sys_clk);
    #1 chk(refHighLevel, 1'h0);
    chk(thresholdCode, th);
    // no pump in this bench, high level allowed
    bus(1'h1, 32'h8, 32'h18 | th);
    // settling wait scaled down to two cycles
    repeat (2) @(posedge sys_clk);
    #1 chk({useInternalRef, refHighLevel}, 2'h3);
    hitN <= 4'h1 << pin;
    @(posedge sys_clk);
    hitN <= 4'h0;
    repeat (20) @(posedge sys_clk);
    rd(32'hc, 32'h1);
    rd(32'h10, 32'h0);
    rd(32'h14, 32'h1 << pin);
    rd(32'h14, 32'h0);
    for (int i = 0; i < 3; i++) begin
      d = $urandom % 8;
      mEn <= !src[i];
      sEn <= src[i];
      syncSlaveMode <= src[i];
      syncMasterMode <= !src[i];
      bus(1'h1, 32'h0, (src[i] << 7) | (d << 1));
      bus(1'h1, 32'h4, (mdv[i] << 5) | osc[i]);
      rate(3 * (src[i] ? 1 : d + 1) * (mdv[i] + 1) * osv[i]);
    end
    end_sim();
  end
endmodule
